// ### verilog/auto_on_map.svh
// register offsets, field positions and reset values of the input auto-on selector
`ifndef AUTO_ON_MAP_SVH
`define AUTO_ON_MAP_SVH

////////////////////////////////////////////////////////////////////////////////
// register byte offsets
`define AO_OFS_SELECT        12'h000
`define AO_OFS_ASSIGN        12'h004
`define AO_OFS_STATUS        12'h008
`define AO_OFS_ACTIVE        12'h00C
`define AO_OFS_RESERVED      12'h010

////////////////////////////////////////////////////////////////////////////////
// auto-on selection word field positions
`define AO_SEL_WIDTH         16
`define AO_BIT_SERVO_ON      2
`define AO_BIT_PROP_CTRL     4
`define AO_BIT_FORCED_STOP   5
`define AO_BIT_FWD_LIMIT     10
`define AO_BIT_REV_LIMIT     11
`define AO_SEL_RESET         16'h0000

////////////////////////////////////////////////////////////////////////////////
// pin assignment / control mode word
`define AO_ASG_BIT_FWD_PIN   0
`define AO_ASG_BIT_REV_PIN   1
`define AO_ASG_MODE_LSB      4
`define AO_ASG_MODE_MSB      5
`define AO_ASG_RESET         16'h0003
`define AO_RESERVED_RESET    16'h0000

////////////////////////////////////////////////////////////////////////////////
// status word field positions
`define AO_STS_FUNC_LSB      0
`define AO_STS_FUNC_MSB      4
`define AO_STS_PIN_LSB       8
`define AO_STS_PIN_MSB       12
`define AO_STS_BIT_PENDING   16
`define AO_STS_BIT_RUN       17

////////////////////////////////////////////////////////////////////////////////
// sequencing
`define AO_LOAD_CYCLES       4'h2

`endif

// ### verilog/auto_on_pkg.sv
// types shared by the input auto-on selector
package auto_on_pkg;

    // one bit per assignable input function
    typedef struct packed {
        logic rev_limit;
        logic fwd_limit;
        logic forced_stop;
        logic prop_ctrl;
        logic servo_on;
    } func_vec_t;

    typedef enum logic [1:0] {
        MODE_POSITION,
        MODE_INT_SPEED,
        MODE_INT_TORQUE,
        MODE_UNUSED
    } ctrl_mode_t;

    // settings that only take effect at power-up
    typedef struct packed {
        logic [15:0] select;
        logic        fwd_pin;
        logic        rev_pin;
        ctrl_mode_t  mode;
    } cfg_t;

    typedef enum logic [1:0] {
        PWR_OFF,
        PWR_LOAD,
        PWR_RUN
    } pwr_state_t;

endpackage

// ### verilog/pin_sync.sv
// two-flip-flop synchroniser for a group of asynchronous input pins
`timescale 1ns/1ps

module pin_sync #(
    parameter int WIDTH = 5
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst,
    // asynchronous pins and their synchronised copies
    input  wire logic [WIDTH-1:0] pin_async,
    output logic      [WIDTH-1:0] pin_sync_r
);

    logic [WIDTH-1:0] meta_r;

    ////////////////////////////////////////////////////////////////////////////
    // the first stage feeds only the second stage
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    meta_r[i]     <= 1'b0;
                    pin_sync_r[i] <= 1'b0;
                end else begin
                    meta_r[i]     <= pin_async[i];
                    pin_sync_r[i] <= meta_r[i];
                end
            end
        end
    endgenerate

endmodule

// ### verilog/input_auto_on_selector.sv
// input auto-on selector: decides whether each input function follows its pin or is forced on
//
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "auto_on_map.svh"

module input_auto_on_selector (
    // clock and reset
    input  wire logic                   clk_sys,
    input  wire logic                   rst,
    // apb slave
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [11:0]            paddr,
    input  wire logic [31:0]            pwdata,
    output logic                        pready,
    output logic [31:0]                 prdata,
    output logic                        pslverr,
    // supply monitor, high while power is good (asynchronous)
    input  wire logic                   power_good,
    // external input pins, active high (asynchronous)
    input  wire logic                   servo_on_request_pin,
    input  wire logic                   proportional_control_request_pin,
    input  wire logic                   forced_stop_input_pin,
    input  wire logic                   forward_stroke_limit_pin,
    input  wire logic                   reverse_stroke_limit_pin,
    // effective function states
    output logic                        servo_on_request,
    output logic                        proportional_control_request,
    output logic                        forced_stop_input,
    output logic                        forward_stroke_limit,
    output logic                        reverse_stroke_limit,
    output logic                        config_running
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations
    auto_on_pkg::cfg_t       staged_r;
    auto_on_pkg::cfg_t       active_r;
    auto_on_pkg::func_vec_t  pin_vec;
    auto_on_pkg::func_vec_t  pin_s;
    auto_on_pkg::func_vec_t  func_nxt;
    auto_on_pkg::func_vec_t  func_r;
    auto_on_pkg::pwr_state_t pwr_state_r;
    logic [15:0]             reserved_r;
    logic [3:0]              load_cnt_r;
    logic [1:0]              pg_meta_r;
    logic                    pg_prev_r;
    logic                    power_good_s;
    logic                    pwr_rise;
    logic                    access;
    logic                    wr_take;
    logic                    rd_take;
    logic                    addr_ok;
    logic                    addr_ro;
    logic [31:0]             rdata_nxt;
    logic                    pending;
    logic [15:0]             assign_word;
    logic [15:0]             active_assign;
    logic                    speed_mode;
    logic                    pwr_run;
    logic                    load_now;
    logic                    bad_req;
    logic                    sel_hit;
    logic                    asg_hit;
    logic                    rsv_hit;
    auto_on_pkg::func_vec_t  force_vec;

    // reset value of the assign word, split into its two pin flags
    localparam logic [15:0] ASG_RESET   = `AO_ASG_RESET;
    localparam logic        FWD_PIN_RST = ASG_RESET[`AO_ASG_BIT_FWD_PIN];
    localparam logic        REV_PIN_RST = ASG_RESET[`AO_ASG_BIT_REV_PIN];

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisation
    assign pin_vec.servo_on    = servo_on_request_pin;
    assign pin_vec.prop_ctrl   = proportional_control_request_pin;
    assign pin_vec.forced_stop = forced_stop_input_pin;
    assign pin_vec.fwd_limit   = forward_stroke_limit_pin;
    assign pin_vec.rev_limit   = reverse_stroke_limit_pin;

    pin_sync #(
        .WIDTH      (5)
    ) u_pin_sync (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .pin_async  (pin_vec),
        .pin_sync_r (pin_s)
    );

    // power-good passes two flops; the edge detector reads only the second
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pg_meta_r <= 2'h0;
            pg_prev_r <= 1'b0;
        end else begin
            pg_meta_r <= {pg_meta_r[0], power_good};
            pg_prev_r <= pg_meta_r[1];
        end
    end

    assign power_good_s = pg_meta_r[1];
    assign pwr_rise     = power_good_s & ~pg_prev_r;

    ////////////////////////////////////////////////////////////////////////////
    // apb decode
    assign access  = psel & penable & ~pready;
    assign addr_ok = (paddr == `AO_OFS_SELECT)  || (paddr == `AO_OFS_ASSIGN)  ||
                     (paddr == `AO_OFS_STATUS)  || (paddr == `AO_OFS_ACTIVE)  ||
                     (paddr == `AO_OFS_RESERVED);
    assign addr_ro = (paddr == `AO_OFS_STATUS) || (paddr == `AO_OFS_ACTIVE);
    // status and active words only reflect state, so writing them is an error
    assign bad_req = ~addr_ok | (pwrite & addr_ro);
    assign wr_take = access & pwrite & addr_ok & ~addr_ro;
    assign rd_take = access & ~pwrite;

    // one hit per writable word
    assign sel_hit = wr_take & (paddr == `AO_OFS_SELECT);
    assign asg_hit = wr_take & (paddr == `AO_OFS_ASSIGN);
    assign rsv_hit = wr_take & (paddr == `AO_OFS_RESERVED);

    // answer one cycle into the access phase, so every transfer takes three edges
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= access;
            pslverr <= access & bad_req;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (rd_take) begin
            prdata <= rdata_nxt;
        end else if (access) begin
            prdata <= 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // staged settings: software writes these, they act only after power-up
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            staged_r.select  <= `AO_SEL_RESET;
            staged_r.fwd_pin <= FWD_PIN_RST;
            staged_r.rev_pin <= REV_PIN_RST;
            staged_r.mode    <= auto_on_pkg::MODE_POSITION;
        end else if (sel_hit) begin
            staged_r.select  <= pwdata[15:0];
        end else if (asg_hit) begin
            staged_r.fwd_pin <= pwdata[`AO_ASG_BIT_FWD_PIN];
            staged_r.rev_pin <= pwdata[`AO_ASG_BIT_REV_PIN];
            staged_r.mode    <= auto_on_pkg::ctrl_mode_t'(
                                    pwdata[`AO_ASG_MODE_MSB:`AO_ASG_MODE_LSB]);
        end
    end

    // reserved word is kept as written; the host is expected to leave it alone
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reserved_r <= `AO_RESERVED_RESET;
        end else if (rsv_hit) begin
            reserved_r <= pwdata[15:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // power sequence: active settings copy the staged ones only at power-up
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pwr_state_r <= auto_on_pkg::PWR_OFF;
            load_cnt_r  <= 4'h0;
        end else begin
            unique case (pwr_state_r)
                auto_on_pkg::PWR_OFF: begin
                    if (pwr_rise) begin
                        pwr_state_r <= auto_on_pkg::PWR_LOAD;
                        load_cnt_r  <= `AO_LOAD_CYCLES;
                    end
                end
                auto_on_pkg::PWR_LOAD: begin
                    if (!power_good_s) begin
                        pwr_state_r <= auto_on_pkg::PWR_OFF;
                    end else if (load_cnt_r == 4'h1) begin
                        pwr_state_r <= auto_on_pkg::PWR_RUN;
                    end
                    load_cnt_r <= load_cnt_r - 4'h1;
                end
                auto_on_pkg::PWR_RUN: begin
                    if (!power_good_s) begin
                        pwr_state_r <= auto_on_pkg::PWR_OFF;
                    end
                end
                // the unused fourth code falls back to power-off rather than sticking
                default: begin
                    pwr_state_r <= auto_on_pkg::PWR_OFF;
                end
            endcase
        end
    end

    // writes during run leave the running setting untouched until the next power-on
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            active_r.select  <= `AO_SEL_RESET;
            active_r.fwd_pin <= FWD_PIN_RST;
            active_r.rev_pin <= REV_PIN_RST;
            active_r.mode    <= auto_on_pkg::MODE_POSITION;
        end else if (load_now) begin
            active_r <= staged_r;
        end
    end

    // copy on the first load cycle only, so settings are taken once per power-up
    assign load_now   = (pwr_state_r == auto_on_pkg::PWR_LOAD) &&
                        (load_cnt_r == `AO_LOAD_CYCLES);
    assign pwr_run    = (pwr_state_r == auto_on_pkg::PWR_RUN);
    // pending tells software that a power cycle is still owed
    assign pending    = (staged_r != active_r);
    assign speed_mode = (active_r.mode == auto_on_pkg::MODE_INT_SPEED);

    ////////////////////////////////////////////////////////////////////////////
    // function resolution
    // selection bits gathered in function order
    assign force_vec.servo_on    = active_r.select[`AO_BIT_SERVO_ON];
    assign force_vec.prop_ctrl   = active_r.select[`AO_BIT_PROP_CTRL];
    assign force_vec.forced_stop = active_r.select[`AO_BIT_FORCED_STOP];
    assign force_vec.fwd_limit   = active_r.select[`AO_BIT_FWD_LIMIT];
    assign force_vec.rev_limit   = active_r.select[`AO_BIT_REV_LIMIT];

    always_comb begin
        func_nxt = '0;
        if (pwr_run) begin
            // a set selection bit forces the function, a clear one passes the pin
            func_nxt = force_vec | pin_s;
            // outside speed mode an unassigned limit still follows its pin input
            if (speed_mode) begin
                if (!active_r.fwd_pin) begin
                    func_nxt.fwd_limit = 1'b1;
                end else begin
                    func_nxt.fwd_limit = force_vec.fwd_limit | pin_s.fwd_limit;
                end
                if (!active_r.rev_pin) begin
                    func_nxt.rev_limit = 1'b1;
                end else begin
                    func_nxt.rev_limit = force_vec.rev_limit | pin_s.rev_limit;
                end
            end
        end
    end

    // outputs stay deasserted while power is down or settings are loading
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            func_r         <= '0;
            config_running <= 1'b0;
        end else begin
            func_r         <= func_nxt;
            config_running <= pwr_run;
        end
    end

    assign servo_on_request             = func_r.servo_on;
    assign proportional_control_request = func_r.prop_ctrl;
    assign forced_stop_input            = func_r.forced_stop;
    assign forward_stroke_limit         = func_r.fwd_limit;
    assign reverse_stroke_limit         = func_r.rev_limit;

    ////////////////////////////////////////////////////////////////////////////
    // read mux
    assign assign_word   = {10'h000, staged_r.mode, 2'h0, staged_r.rev_pin, staged_r.fwd_pin};
    assign active_assign = {10'h000, active_r.mode, 2'h0, active_r.rev_pin, active_r.fwd_pin};

    always_comb begin
        rdata_nxt = 32'h0000_0000;
        unique case (paddr)
            `AO_OFS_SELECT:   rdata_nxt = {16'h0000, staged_r.select};
            `AO_OFS_ASSIGN:   rdata_nxt = {16'h0000, assign_word};
            `AO_OFS_STATUS: begin
                // pins shown after the synchroniser, as the function logic sees them
                rdata_nxt[`AO_STS_FUNC_MSB:`AO_STS_FUNC_LSB] = func_r;
                rdata_nxt[`AO_STS_PIN_MSB:`AO_STS_PIN_LSB]   = pin_s;
                rdata_nxt[`AO_STS_BIT_PENDING]               = pending;
                rdata_nxt[`AO_STS_BIT_RUN]                   = config_running;
            end
            `AO_OFS_ACTIVE:   rdata_nxt = {active_assign, active_r.select};
            `AO_OFS_RESERVED: rdata_nxt = {16'h0000, reserved_r};
            default:          rdata_nxt = 32'h0000_0000;
        endcase
    end

endmodule

// ### tb/pin_driver.sv
// switch model that drives the five function input pins
`timescale 1ns/1ps
module pin_driver (
    // clock
    input  wire logic       clk_sys,
    // wanted and driven pin levels {rev, fwd, stop, prop, servo}
    input  wire logic [4:0] pin_want,
    output logic      [4:0] pin_out = 5'h00
);
    // switches always drive, so a pin never floats between changes
    always @(posedge clk_sys) begin
        pin_out <= pin_want;
    end
endmodule

// ### tb/auto_on_sva.sv
// concurrent checks on the ports of the input auto-on selector
`timescale 1ns/1ps
module auto_on_chk (
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        rst,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    // pins and functions
    input wire logic        servo_on_request_pin,
    input wire logic        reverse_stroke_limit_pin,
    input wire logic        servo_on_request,
    input wire logic        proportional_control_request,
    input wire logic        forced_stop_input,
    input wire logic        forward_stroke_limit,
    input wire logic        reverse_stroke_limit,
    input wire logic        config_running
);
    logic [15:0] st_sel_r;
    logic [15:0] st_asg_r;
    logic [15:0] act_sel_r;
    logic [15:0] act_asg_r;
    logic [2:0]  live_cnt_r;
    logic [4:0]  fo;
    logic        live;
    logic        spd;
    assign fo = {reverse_stroke_limit, forward_stroke_limit, forced_stop_input,
                 proportional_control_request, servo_on_request};
    // settle time after load, so pin history is from the running phase
    assign live = config_running && (live_cnt_r >= 3'h4);
    assign spd = (act_asg_r[5:4] == 2'h1);
    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_sel_r <= 16'h0000;
            st_asg_r <= 16'h0003;
        end else if (psel && penable && pready && pwrite) begin
            if (paddr == 12'h000) st_sel_r <= pwdata[15:0];
            if (paddr == 12'h004) st_asg_r <= pwdata[15:0];
        end
    end
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            act_sel_r <= 16'h0000;
            act_asg_r <= 16'h0003;
        end else if (config_running && (live_cnt_r == 3'h0)) begin
            act_sel_r <= st_sel_r;
            act_asg_r <= st_asg_r;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (rst || !config_running) live_cnt_r <= 3'h0;
        else if (live_cnt_r != 3'h7) live_cnt_r <= live_cnt_r + 3'h1;
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    chk_reset_quiet: assert property (
        $past(rst) |-> !config_running && !pready && (fo == 5'h00)) else $error("not quiet after reset");
    chk_off_zero: assert property (
        !config_running && !$past(config_running) |-> fo == 5'h00) else $error("function live while off");
    chk_servo_force: assert property (
        live && act_sel_r[2] |-> servo_on_request) else $error("servo-on not forced");
    chk_fwd_force: assert property (
        live && act_sel_r[10] |-> forward_stroke_limit) else $error("forward limit not forced");
    chk_rev_force: assert property (
        live && act_sel_r[11] |-> reverse_stroke_limit) else $error("reverse limit not forced");
    chk_servo_follow: assert property (
        live && !act_sel_r[2] |-> servo_on_request == $past(servo_on_request_pin, 3))
        else $error("servo-on does not follow pin");
    chk_speed_open: assert property (
        live && spd && !act_asg_r[0] |-> forward_stroke_limit) else $error("open limit not on");
    chk_speed_pinned: assert property (
        live && spd && act_asg_r[1] && !act_sel_r[11] |->
        reverse_stroke_limit == $past(reverse_stroke_limit_pin, 3)) else $error("pinned limit wrong");
endmodule

bind input_auto_on_selector auto_on_chk u_chk (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .servo_on_request_pin, .reverse_stroke_limit_pin, .servo_on_request,
    .proportional_control_request, .forced_stop_input, .forward_stroke_limit,
    .reverse_stroke_limit, .config_running);

// ### tb/tb_input_auto_on_selector.sv
// self-checking bench for the input auto-on selector
`timescale 1ns/1ps
module tb_input_auto_on_selector;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        power_good = 1'b0;
    logic [4:0]  pin_want = 5'h00;
    logic [4:0]  pins;
    logic [4:0]  func;
    logic        config_running;
    logic [4:0]  p = 5'h00;
    logic [33:0] notes[$];
    logic [31:0] seed = 32'h00000025;
    logic [15:0] st_sel = 16'h0000;
    logic [15:0] st_asg = 16'h0003;
    logic [15:0] act_sel = 16'h0000;
    logic [15:0] act_asg = 16'h0003;
    // {select, assign}: follow, servo, both limits, fwd, rev, speed cases
    logic [31:0] cases[8] = '{32'h00000003, 32'h00040003, 32'h0C000003, 32'h04000003,
                              32'h08000003, 32'h00000010, 32'h04000013, 32'h00300011};
    int          fails = 0;
    int          compares = 0;
    int          i;
    int          k;

    input_auto_on_selector uut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .power_good(power_good), .servo_on_request_pin(pins[0]),
        .proportional_control_request_pin(pins[1]), .forced_stop_input_pin(pins[2]),
        .forward_stroke_limit_pin(pins[3]), .reverse_stroke_limit_pin(pins[4]),
        .servo_on_request(func[0]), .proportional_control_request(func[1]),
        .forced_stop_input(func[2]), .forward_stroke_limit(func[3]),
        .reverse_stroke_limit(func[4]), .config_running(config_running));
    pin_driver u_pins (.clk_sys(clk_sys), .pin_want(pin_want), .pin_out(pins));

    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end
    ////////////////////////////////////////////////////////////////////////////
    function logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function logic [4:0] fexp(input logic [4:0] pv);
        logic [4:0] f;
        f = pv | {act_sel[11], act_sel[10], act_sel[5], act_sel[4], act_sel[2]};
        // speed mode: a limit without a pin is on whatever the selection says
        if (act_asg[5:4] == 2'h1) begin
            if (!act_asg[0]) f[3] = 1'b1;
            if (!act_asg[1]) f[4] = 1'b1;
        end
        return f;
    endfunction
    function logic [31:0] sts(input logic [4:0] f, input logic [4:0] pv, input logic pend,
                              input logic run);
        return {14'h0000, run, pend, 3'h0, pv, 3'h0, f};
    endfunction
    task end_sim();
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task check(input logic [32:0] seen, input logic [32:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // note = {check data, expect error, expected data}
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [33:0] n);
        notes.push_back(n);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        // pready is sampled at the rising edge; the request stands until it is seen high
        i = 0;
        do begin
            @(posedge clk_sys);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (pready !== 1'b1) begin
            fails++;
            end_sim();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, {2'b10, 32'h00000000});
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h00000000, {2'b10, e});
    endtask
    ////////////////////////////////////////////////////////////////////////////
    always @(negedge clk_sys) begin
        logic [33:0] n;
        if (pready === 1'b1) begin
            n = (notes.size() > 0) ? notes.pop_front() : {2'b11, 32'hFFFFFFFF};
            check({pslverr, n[33] ? prdata : 32'h00000000}, n[32:0]);
        end
    end
    initial begin
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        rd(12'h000, 32'h00000000);
        rd(12'h004, 32'h00000003);
        rd(12'h00C, 32'h00030000);
        wr(12'h010, 32'h00000000);
        rd(12'h010, 32'h00000000);
        apb(1'b0, 12'h014, 32'h00000000, {2'b01, 32'h00000000});
        apb(1'b1, 12'h008, 32'h0000000F, {2'b01, 32'h00000000});
        $display("test registers done");
        for (k = 0; k < 8; k++) begin
            power_good <= 1'b0;
            repeat (8) @(posedge clk_sys);
            st_sel = cases[k][31:16];
            st_asg = cases[k][15:0];
            wr(12'h000, {16'h0000, st_sel});
            wr(12'h004, {16'h0000, st_asg});
            rd(12'h008, sts(5'h00, p, (st_sel != act_sel) || (st_asg != act_asg), 1'b0));
            power_good <= 1'b1;
            for (i = 0; i < 50 && config_running !== 1'b1; i++) @(negedge clk_sys);
            if (i == 50) begin
                fails++;
                end_sim();
            end
            act_sel = st_sel;
            act_asg = st_asg;
            rd(12'h00C, {act_asg, act_sel});
            repeat (2) begin
                p = 5'(xs() >> 27);
                pin_want <= p;
                repeat (6) @(posedge clk_sys);
                rd(12'h008, sts(fexp(p), p, 1'b0, 1'b1));
            end
            // staged change while running must wait for the next power cycle
            wr(12'h000, {16'h0000, st_sel ^ 16'h0C34});
            rd(12'h008, sts(fexp(p), p, 1'b1, 1'b1));
            $display("test case %0d done", k);
        end
        end_sim();
    end
endmodule
